// >>> prc_consts.svh
// Offsets, field positions, reset values and timing counts of the reset and power-down control
// How it works
// - Each time the hardware reset input is held low for at least 100 cycles, every control, interrupt and bus register returns to its initial value.
// - Every hardware reset also re-samples and restores the strap-selected configuration.
// - After reset the shared pin serves as the power-down input.
// - The shared pin changes role only through a register write issued by the host, or back to power-down on a reset.
// - In its power-down role, a low level on the shared pin puts the device into power-down.
// - In its interrupt role the shared pin is pulled low while an unmasked interrupt is pending and is otherwise released.
// - A host write setting bit 0 of the register at 0x00d0 switches the internal linear regulator off.
`ifndef PRC_CONSTS_SVH
`define PRC_CONSTS_SVH

`define PRC_CLK_MHZ          100
`define PRC_RESET_MIN_NS     1000
`define PRC_RESET_MIN_CYC    ((`PRC_RESET_MIN_NS * `PRC_CLK_MHZ + 999) / 1000)

`define PRC_OFF_PIN_CTRL     12'h000
`define PRC_OFF_STATE        12'h004
`define PRC_OFF_IRQ_STATUS   12'h008
`define PRC_OFF_IRQ_MASK     12'h00c
`define PRC_OFF_STRAPS       12'h010
`define PRC_OFF_REGULATOR    12'h0d0

`define PRC_BIT_IRQ_MODE     0
`define PRC_BIT_REG_OFF      0
`define PRC_EV_PD_ENTER      0
`define PRC_EV_PD_EXIT       1
`define PRC_EV_EXT           2

`define PRC_RST_PIN_CTRL     1'b0
`define PRC_RST_REGULATOR    16'h0000
`define PRC_RST_IRQ_MASK     3'h0

`define PRC_RESP_OKAY        2'h0
`define PRC_RESP_SLVERR      2'h2

`endif

// >>> prc_ctrl_assertions.sv
// Port checker for the reset and power-down control
`timescale 1ns/1ns
module prc_ctrl_chk
  import prc_pkg::*;
(
  input wire logic         ref_clk,
  input wire logic         rst,
  input wire logic         hw_reset_n,
  input wire logic [7:0]   strap_pins,
  input wire logic         irq_event,
  input wire logic         shared_irq_sleep_pin_in,
  input wire logic         shared_irq_sleep_pin_out,
  input wire logic         shared_irq_sleep_pin_oe,
  input wire logic         power_down,
  input wire logic         regulator_off,
  input wire logic         core_reset,
  input wire logic [7:0]   strap_value,
  input wire logic         irq,
  input wire prc_axi_req_s axi_req,
  input wire prc_axi_rsp_s axi_rsp
);
  localparam int HW_LAT = 106;
  logic [11:0] wa;
  logic [31:0] wd;
  logic        mode;
  logic [7:0]  lowcnt;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Role mirror lags the design by a cycle, so role checks span two cycles and the pin windows also demand bvalid low
  always_ff @(posedge ref_clk) begin
    if (axi_req.awvalid && axi_rsp.awready) wa <= axi_req.awaddr;
    if (axi_req.wvalid && axi_rsp.wready) wd <= axi_req.wdata;
    lowcnt <= hw_reset_n ? 8'h00 : lowcnt + {7'h00, lowcnt != 8'hff};
    if (rst || core_reset) mode <= 1'b0;
    else if ($rose(axi_rsp.bvalid) && wa == 12'h000 && axi_rsp.bresp == 2'h0) mode <= wd[0];
  end
  //////////////////////////////////////////////////
  pin_low_a: assert property (!shared_irq_sleep_pin_out) else $error("pin driven high");
  oe_irq_a: assert property (shared_irq_sleep_pin_oe |-> irq && !power_down) else $error("pull without irq");
  irq_role_a: assert property (mode [*2] |-> shared_irq_sleep_pin_oe == irq && !power_down)
    else $error("irq role mismatch");
  pd_role_a: assert property (!mode [*2] |-> !shared_irq_sleep_pin_oe) else $error("pull in sleep role");
  pd_enter_a: assert property ((!shared_irq_sleep_pin_in && !mode && !axi_rsp.bvalid && !core_reset) [*5]
    |-> power_down) else $error("no power down");
  pd_exit_a: assert property ((shared_irq_sleep_pin_in && !mode && !axi_rsp.bvalid) [*5] |-> !power_down)
    else $error("power down stuck");
  clear_a: assert property (core_reset [*2] |-> !irq && !regulator_off && !power_down)
    else $error("outputs not cleared");
  hw_rst_a: assert property (lowcnt >= HW_LAT |-> core_reset) else $error("long reset ignored");
  strap_a: assert property (!core_reset && !$past(core_reset) |-> $stable(strap_value))
    else $error("straps moved");
  reg_off_a: assert property ($rose(axi_rsp.bvalid) && wa == 12'h0d0 && axi_rsp.bresp == 2'h0
    |-> ##[0:1] regulator_off == wd[0]) else $error("regulator bit wrong");
  cover property ($rose(power_down));
  cover property ($rose(shared_irq_sleep_pin_oe));
  cover property ($rose(regulator_off));
  cover property ($rose(core_reset));
endmodule : prc_ctrl_chk

bind prc_phy_reset_powerdown_ctrl prc_ctrl_chk u_chk (.ref_clk(ref_clk), .rst(rst), .hw_reset_n(hw_reset_n),
  .strap_pins(strap_pins), .irq_event(irq_event), .shared_irq_sleep_pin_in(shared_irq_sleep_pin_in),
  .shared_irq_sleep_pin_out(shared_irq_sleep_pin_out), .shared_irq_sleep_pin_oe(shared_irq_sleep_pin_oe),
  .power_down(power_down), .regulator_off(regulator_off), .core_reset(core_reset), .strap_value(strap_value),
  .irq(irq), .axi_req(axi_req), .axi_rsp(axi_rsp));

// >>> prc_host_model.sv
// Host controller model: hardware reset pin and shared open-drain pin
`timescale 1ns/1ns
module prc_host_model (
  input  wire logic ref_clk,
  input  wire logic pin_oe,
  input  wire logic pin_out,
  output logic      hw_reset_n,
  output wire logic pin_level
);
  logic pull_low = 1'b0;
  initial hw_reset_n = 1'b1;
  // Pull-up wins only when nobody pulls low
  assign pin_level = !(pull_low || (pin_oe && !pin_out));
  task sleep(input logic on);
    @(posedge ref_clk);
    pull_low <= on;
  endtask : sleep
  task hw_reset(input int cyc);
    @(posedge ref_clk);
    hw_reset_n <= 1'b0;
    repeat (cyc) @(posedge ref_clk);
    hw_reset_n <= 1'b1;
  endtask : hw_reset
endmodule : prc_host_model

// >>> prc_phy_reset_powerdown_ctrl.sv
// Reset filter, strap capture, shared power-down/interrupt pin and register file on AXI4-Lite
`timescale 1ns/1ns
`include "prc_consts.svh"

module prc_phy_reset_powerdown_ctrl
  import prc_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         hw_reset_n,
  input  wire logic [7:0]   strap_pins,
  input  wire logic         irq_event,
  input  wire logic         shared_irq_sleep_pin_in,
  output      logic         shared_irq_sleep_pin_out,
  output      logic         shared_irq_sleep_pin_oe,
  output      logic         power_down,
  output      logic         regulator_off,
  output      logic         core_reset,
  output      logic [7:0]   strap_value,
  output      logic         irq,
  input  wire prc_axi_req_s axi_req,
  output      prc_axi_rsp_s axi_rsp
);

  localparam logic [6:0] RESET_MIN = 7'(`PRC_RESET_MIN_CYC);

  function automatic prc_reg_e decode(input logic [11:0] addr);
    unique case (addr)
      `PRC_OFF_PIN_CTRL:   decode = PRC_REG_PIN_CTRL;
      `PRC_OFF_STATE:      decode = PRC_REG_STATE;
      `PRC_OFF_IRQ_STATUS: decode = PRC_REG_IRQ_STATUS;
      `PRC_OFF_IRQ_MASK:   decode = PRC_REG_IRQ_MASK;
      `PRC_OFF_STRAPS:     decode = PRC_REG_STRAPS;
      `PRC_OFF_REGULATOR:  decode = PRC_REG_REGULATOR;
      default:             decode = PRC_REG_NONE;
    endcase
  endfunction : decode

  function automatic logic [31:0] merge(input logic [31:0] old_val, input logic [31:0] new_val,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    merge = res;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and hardware reset filter

  logic       rstn_meta, rstn_sync;
  logic       pin_meta, pin_sync;
  logic [7:0] strap_meta, strap_sync;
  logic [6:0] low_cnt, next_low_cnt;
  logic       hw_reset_active, next_hw_reset_active;
  logic       clr;

  always_ff @(posedge ref_clk) begin
    rstn_meta  <= hw_reset_n;
    rstn_sync  <= rstn_meta;
    pin_meta   <= shared_irq_sleep_pin_in;
    pin_sync   <= pin_meta;
    strap_meta <= strap_pins;
    strap_sync <= strap_meta;
  end

  // Short dips are ignored so a glitch cannot wipe the device; the controller must hold the pin low
  always_comb begin
    next_low_cnt         = low_cnt;
    next_hw_reset_active = 1'b0;
    if (rstn_sync) begin
      next_low_cnt = 7'h00;
    end else if (low_cnt != RESET_MIN) begin
      next_low_cnt = low_cnt + 7'h01;
    end
    if (!rstn_sync && next_low_cnt == RESET_MIN) begin
      next_hw_reset_active = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      low_cnt         <= 7'h00;
      hw_reset_active <= 1'b0;
    end else begin
      low_cnt         <= next_low_cnt;
      hw_reset_active <= next_hw_reset_active;
    end
  end

  // Every state register below except strap_value is loaded with its reset value (core_reset high, the rest cleared) by either reset source, on every assertion
  assign clr = rst | hw_reset_active;

  ////////////////////////////////////////////////////////////////////////////////
  // Register file and shared pin state

  logic        irq_mode, next_irq_mode;
  logic [15:0] regulator_reg, next_regulator_reg;
  logic [2:0]  irq_status, next_irq_status;
  logic [2:0]  irq_mask, next_irq_mask;
  logic [7:0]  next_strap_value;
  logic        next_power_down;
  logic        next_irq;
  logic        next_pin_oe;
  logic [2:0]  events;
  logic        wr_fire;
  prc_reg_e    wr_reg;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;

  always_comb begin
    events                    = 3'h0;
    events[`PRC_EV_PD_ENTER]  = next_power_down & ~power_down;
    events[`PRC_EV_PD_EXIT]   = ~next_power_down & power_down;
    events[`PRC_EV_EXT]       = irq_event;
  end

  always_comb begin
    next_irq_mode      = irq_mode;
    next_regulator_reg = regulator_reg;
    next_irq_mask      = irq_mask;
    next_irq_status    = irq_status;
    if (wr_fire) begin
      unique case (wr_reg)
        PRC_REG_PIN_CTRL: begin
          if (wr_strb[0]) begin
            next_irq_mode = wr_data[`PRC_BIT_IRQ_MODE];
          end
        end
        PRC_REG_REGULATOR: begin
          next_regulator_reg = 16'(merge({16'h0000, regulator_reg}, wr_data, wr_strb));
        end
        PRC_REG_IRQ_MASK: begin
          if (wr_strb[0]) begin
            next_irq_mask = wr_data[2:0];
          end
        end
        PRC_REG_IRQ_STATUS: begin
          if (wr_strb[0]) begin
            next_irq_status = irq_status & ~wr_data[2:0];
          end
        end
        default: begin
        end
      endcase
    end
    // A new event in the clearing cycle survives the write-one-to-clear
    next_irq_status = next_irq_status | events;
  end

  always_comb begin
    // The pin is an input only while in power-down role; a released high pin wakes the device
    next_power_down = ~irq_mode & ~pin_sync;
    next_irq        = |(next_irq_status & next_irq_mask);
    // Open drain: only ever drive low, and only in interrupt role
    next_pin_oe     = next_irq_mode & next_irq;
  end

  // Straps are re-sampled while any reset is held, so the latched value is the one at release
  always_comb begin
    next_strap_value = strap_value;
    if (clr) begin
      next_strap_value = strap_sync;
    end
  end

  always_ff @(posedge ref_clk) begin
    strap_value <= next_strap_value;
    if (clr) begin
      irq_mode                 <= `PRC_RST_PIN_CTRL;
      regulator_reg            <= `PRC_RST_REGULATOR;
      irq_mask                 <= `PRC_RST_IRQ_MASK;
      irq_status               <= 3'h0;
      power_down               <= 1'b0;
      irq                      <= 1'b0;
      shared_irq_sleep_pin_oe  <= 1'b0;
      shared_irq_sleep_pin_out <= 1'b0;
      regulator_off            <= 1'b0;
      core_reset               <= 1'b1;
    end else begin
      irq_mode                 <= next_irq_mode;
      regulator_reg            <= next_regulator_reg;
      irq_mask                 <= next_irq_mask;
      irq_status               <= next_irq_status;
      power_down               <= next_power_down;
      irq                      <= next_irq;
      shared_irq_sleep_pin_oe  <= next_pin_oe;
      shared_irq_sleep_pin_out <= 1'b0;
      regulator_off            <= next_regulator_reg[`PRC_BIT_REG_OFF];
      core_reset               <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel

  logic        aw_held, next_aw_held;
  logic [11:0] aw_addr, next_aw_addr;
  logic        w_held, next_w_held;
  logic [31:0] w_data, next_w_data;
  logic [3:0]  w_strb, next_w_strb;
  logic        bvalid, next_bvalid;
  logic [1:0]  bresp, next_bresp;
  logic        awready, next_awready;
  logic        wready, next_wready;

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    wr_fire      = 1'b0;
    if (axi_req.awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && wready) begin
      next_w_held = 1'b1;
      next_w_data = axi_req.wdata;
      next_w_strb = axi_req.wstrb;
    end
    if (bvalid && axi_req.bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_held && w_held && !bvalid) begin
      wr_fire      = 1'b1;
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (decode(aw_addr) == PRC_REG_NONE) ? `PRC_RESP_SLVERR : `PRC_RESP_OKAY;
    end
    next_awready = ~next_aw_held & ~(axi_req.awvalid & awready);
    next_wready  = ~next_w_held & ~(axi_req.wvalid & wready);
  end

  assign wr_reg  = decode(aw_addr);
  assign wr_data = w_data;
  assign wr_strb = w_strb;

  always_ff @(posedge ref_clk) begin
    if (clr) begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
      w_held  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= `PRC_RESP_OKAY;
      awready <= 1'b0;
      wready  <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held  <= next_w_held;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      awready <= next_awready;
      wready  <= next_wready;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  logic        arready, next_arready;
  logic        rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0]  rresp, next_rresp;
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (decode(axi_req.araddr))
      PRC_REG_PIN_CTRL:   rd_word[`PRC_BIT_IRQ_MODE] = irq_mode;
      PRC_REG_STATE:      rd_word[3:0] = {regulator_off, shared_irq_sleep_pin_oe, pin_sync, power_down};
      PRC_REG_IRQ_STATUS: rd_word[2:0] = irq_status;
      PRC_REG_IRQ_MASK:   rd_word[2:0] = irq_mask;
      PRC_REG_STRAPS:     rd_word[7:0] = strap_value;
      PRC_REG_REGULATOR:  rd_word[15:0] = regulator_reg;
      default:            rd_word = 32'h0000_0000;
    endcase
  end

  always_comb begin
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    next_arready = arready;
    if (rvalid && axi_req.rready) begin
      next_rvalid  = 1'b0;
      next_arready = 1'b1;
    end
    if (axi_req.arvalid && arready) begin
      next_rvalid  = 1'b1;
      next_arready = 1'b0;
      next_rdata   = rd_word;
      next_rresp   = (decode(axi_req.araddr) == PRC_REG_NONE) ? `PRC_RESP_SLVERR : `PRC_RESP_OKAY;
    end
    if (!rvalid && !arready && !(axi_req.arvalid && arready)) begin
      next_arready = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clr) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `PRC_RESP_OKAY;
    end else begin
      arready <= next_arready;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
    end
  end

  always_comb begin
    axi_rsp.awready = awready;
    axi_rsp.wready  = wready;
    axi_rsp.bvalid  = bvalid;
    axi_rsp.bresp   = bresp;
    axi_rsp.arready = arready;
    axi_rsp.rvalid  = rvalid;
    axi_rsp.rdata   = rdata;
    axi_rsp.rresp   = rresp;
  end

endmodule : prc_phy_reset_powerdown_ctrl

// >>> prc_pkg.sv
// Types shared by the reset and power-down control
package prc_pkg;

  typedef struct packed {
    logic        awvalid;
    logic [11:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [11:0] araddr;
    logic        rready;
  } prc_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } prc_axi_rsp_s;

  typedef enum logic [2:0] {
    PRC_REG_PIN_CTRL,
    PRC_REG_STATE,
    PRC_REG_IRQ_STATUS,
    PRC_REG_IRQ_MASK,
    PRC_REG_STRAPS,
    PRC_REG_REGULATOR,
    PRC_REG_NONE
  } prc_reg_e;

endpackage : prc_pkg

// >>> tb_phy_reset_powerdown_ctrl.sv
// Self-checking bench for the reset and power-down control
`timescale 1ns/1ns
module tb_phy_reset_powerdown_ctrl
  import prc_pkg::*;
;
  logic         ref_clk   = 1'b0;
  logic         rst       = 1'b1;
  logic         irq_event = 1'b0;
  logic [7:0]   strap_pins;
  logic         pin_out, pin_oe, power_down, regulator_off, core_reset, irq, hw_reset_n, pin_level;
  logic [7:0]   strap_value;
  prc_axi_req_s axi_req   = '0;
  prc_axi_rsp_s axi_rsp;
  logic [33:0]  exp_q[$];
  logic [31:0]  rnd;
  logic [1:0]   bresp;
  logic [3:0]   strb      = 4'hf;
  int           bad_count = 0;
  int           n_checks  = 0;
  always #5 ref_clk = ~ref_clk;
  prc_phy_reset_powerdown_ctrl DUT (.ref_clk(ref_clk), .rst(rst), .hw_reset_n(hw_reset_n),
    .strap_pins(strap_pins), .irq_event(irq_event), .shared_irq_sleep_pin_in(pin_level),
    .shared_irq_sleep_pin_out(pin_out), .shared_irq_sleep_pin_oe(pin_oe), .power_down(power_down),
    .regulator_off(regulator_off), .core_reset(core_reset), .strap_value(strap_value), .irq(irq),
    .axi_req(axi_req), .axi_rsp(axi_rsp));
  prc_host_model host (.ref_clk(ref_clk), .pin_oe(pin_oe), .pin_out(pin_out), .hw_reset_n(hw_reset_n),
    .pin_level(pin_level));
  //////////////////////////////////////////////////
  task chk(input logic [33:0] got, input logic [33:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= a;
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= d;
    axi_req.wstrb <= strb;
    axi_req.bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
    end while (!axi_rsp.bvalid);
    axi_req.bready <= 1'b0;
    bresp = axi_rsp.bresp;
  endtask : wr
  // Expectation is queued here and judged by the read monitor
  task rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back({r, d});
    @(posedge ref_clk);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= a;
    axi_req.rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
    end while (!axi_rsp.rvalid);
    axi_req.rready <= 1'b0;
  endtask : rd
  task pulse;
    @(posedge ref_clk);
    irq_event <= 1'b1;
    @(posedge ref_clk);
    irq_event <= 1'b0;
    cyc(4);
  endtask : pulse
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  always @(posedge ref_clk) begin
    if (axi_rsp.rvalid && axi_req.rready) begin
      if (exp_q.size() == 0) chk(34'h0, 34'h1, "stray read");
      else chk({axi_rsp.rresp, axi_rsp.rdata}, exp_q.pop_front(), "read");
    end
  end
  initial begin
    cyc(5000);
    bad_count++;
    print_verdict();
  end
  //////////////////////////////////////////////////
  initial begin
    rnd = $urandom(93967);
    strap_pins = rnd[7:0];
    cyc(12);
    rst <= 1'b0;
    cyc(2);
    rd(12'h000, 32'h0, 2'h0);
    rd(12'h00c, 32'h0, 2'h0);
    rd(12'h0d0, 32'h0, 2'h0);
    rd(12'h010, {24'h0, strap_pins}, 2'h0);
    $display("test reset values done");
    host.sleep(1'b1);
    cyc(5);
    chk(power_down, 1'b1, "sleep entry");
    host.sleep(1'b0);
    cyc(5);
    chk(power_down, 1'b0, "sleep exit");
    rd(12'h008, 32'h3, 2'h0);
    wr(12'h008, 32'h3);
    rd(12'h008, 32'h0, 2'h0);
    $display("test sleep role done");
    wr(12'h000, 32'h1);
    wr(12'h00c, 32'h4);
    pulse();
    chk({irq, pin_oe, pin_level, power_down}, 4'b1100, "irq pull");
    rd(12'h004, 32'h4, 2'h0);
    wr(12'h008, 32'h7);
    cyc(2);
    chk({irq, pin_oe, pin_level}, 3'b001, "irq release");
    host.sleep(1'b1);
    cyc(5);
    chk(power_down, 1'b0, "pin ignored in irq role");
    host.sleep(1'b0);
    wr(12'h00c, 32'h0);
    pulse();
    chk(irq, 1'b0, "masked irq");
    rd(12'h008, 32'h4, 2'h0);
    wr(12'h008, 32'h7);
    wr(12'h000, 32'h0);
    $display("test irq role done");
    rnd = $urandom;
    // Random byte lanes; lane 0 always written so the off bit lands
    strb = 4'($urandom) | 4'h1;
    wr(12'h0d0, {rnd[31:1], 1'b1});
    cyc(1);
    chk(regulator_off, 1'b1, "regulator off");
    rd(12'h0d0, {16'h0, {8{strb[1]}} & rnd[15:8], rnd[7:1], 1'b1}, 2'h0);
    strb = 4'hf;
    wr(12'h020, rnd);
    chk(bresp, 2'h2, "unmapped write");
    rd(12'h020, 32'h0, 2'h2);
    $display("test registers done");
    host.hw_reset(20);
    cyc(6);
    chk(regulator_off, 1'b1, "short pulse");
    strap_pins <= ~strap_pins;
    wr(12'h000, 32'h1);
    host.hw_reset(120);
    cyc(6);
    chk({regulator_off, core_reset}, 2'b00, "hw reset");
    rd(12'h000, 32'h0, 2'h0);
    rd(12'h010, {24'h0, strap_pins}, 2'h0);
    $display("test hw reset done");
    cyc(4);
    print_verdict();
  end
endmodule : tb_phy_reset_powerdown_ctrl
